// File: eth_stats_pkg.sv
// How it works
// - status registers are read-only; a read returns the value then clears it
// - register reset clears transmit and receive status registers together
// - receive-path reset clears only receive-side status registers
// - transmit-path reset clears only transmit-side status registers
// - snapshot trigger comes from the pulse pin or a tick register write
// - mode bit 30 low selects the pin, high selects the tick register
// - a trigger copies accumulators to readable counters and clears them together
// - one trigger updates every readable counter for a common interval
// - readable counters have no reset; undefined until the first trigger
// - interval counter counts receive core cycles between triggers, low and high word
// - statistics counters are 48 bits wide
// - counters saturate at all ones instead of wrapping
// - readable counters hold their value between triggers
// - low word holds bits 31:0, high word 4 bytes above holds bits 47:32
// - register reset clears transmit and receive accumulators
// - a trigger pulse clears transmit and receive accumulators
// - receive-path reset clears only receive-side accumulators
// - transmit-path reset clears only transmit-side accumulators
// - flow-control registers exist only in the mac plus pcs build
// - the core-speed switch register exists only with runtime speed switching
// - full 32-bit aligned words; byte write strobes are ignored
// - unlisted offsets are reserved and answered with an error response
package eth_stats_pkg;

    typedef logic [15:0] offset_t;
    typedef enum logic [1:0] {SIDE_GEN, SIDE_TX, SIDE_RX} side_t;

    // ****************************************************************
    // control registers
    // ****************************************************************
    localparam offset_t     MODE_OFS     = 16'h0008;
    localparam offset_t     TICK_OFS     = 16'h0020;
    localparam int          TICK_SEL_BIT = 30;
    localparam int          TICK_BIT     = 0;
    localparam logic [31:0] MODE_RESET   = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET    = 32'h0000_0000;

    localparam int      NUM_CFG       = 18;
    localparam int      FLOW_CFG_LAST = 3;
    localparam int      SPEED_CFG_IDX = 17;
    localparam offset_t CFG_OFS [NUM_CFG] = '{
        16'h0094, 16'h0098, 16'h009c, 16'h00a0, 16'h00d4, 16'h00e0,
        16'h00e4, 16'h00f8, 16'h0100, 16'h0104, 16'h0108, 16'h010c,
        16'h0110, 16'h0114, 16'h0130, 16'h0134, 16'h0138, 16'h013c};

    // ****************************************************************
    // clear-on-read status registers
    // ****************************************************************
    localparam int      NUM_STATUS   = 27;
    localparam int      TX_PAUSE_IDX = 15;
    localparam int      RX_PAUSE_IDX = 16;
    localparam offset_t STATUS_OFS [NUM_STATUS] = '{
        16'h0400, 16'h0404, 16'h0408, 16'h040c, 16'h0410, 16'h0414, 16'h0418,
        16'h041c, 16'h0420, 16'h0424, 16'h0428, 16'h043c, 16'h0440, 16'h0448,
        16'h044c, 16'h0450, 16'h0454, 16'h0458, 16'h045c, 16'h0460, 16'h0464,
        16'h0468, 16'h046c, 16'h0470, 16'h0474, 16'h0478, 16'h047c};
    localparam side_t STATUS_SIDE [NUM_STATUS] = '{
        SIDE_TX,  SIDE_RX,  SIDE_GEN, SIDE_RX,  SIDE_RX,  SIDE_RX,  SIDE_RX,
        SIDE_RX,  SIDE_RX,  SIDE_RX,  SIDE_RX,  SIDE_RX,  SIDE_RX,  SIDE_RX,
        SIDE_TX,  SIDE_TX,  SIDE_RX,  SIDE_GEN, SIDE_GEN, SIDE_GEN, SIDE_GEN,
        SIDE_GEN, SIDE_GEN, SIDE_GEN, SIDE_GEN, SIDE_GEN, SIDE_GEN};

    // ****************************************************************
    // statistics counters
    // ****************************************************************
    localparam int      CNT_W        = 48;
    localparam offset_t HI_WORD_STEP = 16'h0004;
    localparam offset_t CYCLE_OFS    = 16'h0500;
    localparam int      NUM_CNT      = 5;
    localparam int      TX_FRAME_IDX = 4;
    localparam offset_t CNT_OFS [NUM_CNT] = '{
        16'h0508, 16'h0510, 16'h0518, 16'h0520, 16'h06a0};
    localparam side_t CNT_SIDE [NUM_CNT] = '{
        SIDE_RX, SIDE_RX, SIDE_RX, SIDE_RX, SIDE_TX};

    // ****************************************************************
    // bus answers
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : eth_stats_pkg

// File: stat_accum_counter.sv
`timescale 1ns/1ps
`default_nettype none

module stat_accum_counter
    import eth_stats_pkg::*;
(
    input  wire logic             clock,      // core clock
    input  wire logic             rst,        // register reset, async high
    input  wire logic             side_reset, // path reset of this counter's side
    input  wire logic             event_in,   // one count per cycle high
    input  wire logic             snapshot,   // common snapshot trigger
    output logic      [CNT_W-1:0] value_q     // readable snapshot
);

    logic [CNT_W-1:0] acc_q;
    logic [CNT_W-1:0] acc_d;
    logic             loaded_q;

    // ****************************************************************
    // saturating accumulator
    // ****************************************************************
    always_comb begin
        acc_d = acc_q;
        if (event_in && acc_q != {CNT_W{1'b1}}) begin
            acc_d = acc_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
        end else if (side_reset || snapshot) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // readable value is unknown until the first snapshot
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loaded_q <= 1'b0;
        end else if (snapshot) begin
            loaded_q <= 1'b1;
        end
    end

    // event of the trigger cycle goes into the snapshot, so none is lost
    always_ff @(posedge clock) begin
        if (snapshot) begin
            value_q <= acc_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_snap_copy: assert property (snapshot |=> value_q == $past(acc_d) && acc_q == '0)
        else $error("snapshot did not move and clear the accumulator");
    a_value_hold: assert property (loaded_q && !snapshot |=> $stable(value_q))
        else $error("readable counter changed without a snapshot");
    a_acc_saturate: assert property ((acc_q == {CNT_W{1'b1}}) && !snapshot && !side_reset
        |=> acc_q == {CNT_W{1'b1}})
        else $error("accumulator wrapped past all ones");
    a_acc_count: assert property (event_in && !snapshot && !side_reset && acc_q != {CNT_W{1'b1}}
        |=> acc_q == $past(acc_q) + {{(CNT_W-1){1'b0}}, 1'b1})
        else $error("accumulator missed an event");
    a_side_clear: assert property (side_reset |=> acc_q == '0)
        else $error("path reset did not clear the accumulator");

endmodule : stat_accum_counter

`default_nettype wire

// File: eth_status_and_stats_regs.sv
`timescale 1ns/1ps
`default_nettype none

module eth_status_and_stats_regs
    import eth_stats_pkg::*;
#(
    parameter bit MAC_PCS        = 1'b1, // full mac plus pcs build
    parameter bit RUNTIME_SWITCH = 1'b0  // runtime speed switching built
) (
    input  wire logic                         clock,             // host and core clock, 50 MHz
    input  wire logic                         rst,               // register reset, async high
    input  wire logic                         tx_reset,          // transmit path reset
    input  wire logic                         rx_reset,          // receive path reset
    input  wire logic                         snapshot_pulse_in, // snapshot trigger pin
    input  wire logic [NUM_STATUS-1:0][31:0]  status_set_in,     // status bits raised by datapaths
    input  wire logic [NUM_CNT-1:0]           cnt_event_in,      // per-counter event pulses
    input  wire logic [31:0]                  s_axi_awaddr,      // write address
    input  wire logic                         s_axi_awvalid,     // write address valid
    output logic                              s_axi_awready,     // write address ready
    input  wire logic [31:0]                  s_axi_wdata,       // write data
    input  wire logic [3:0]                   s_axi_wstrb,       // byte strobes, ignored
    input  wire logic                         s_axi_wvalid,      // write data valid
    output logic                              s_axi_wready,      // write data ready
    output logic      [1:0]                   s_axi_bresp,       // write response
    output logic                              s_axi_bvalid,      // write response valid
    input  wire logic                         s_axi_bready,      // write response ready
    input  wire logic [31:0]                  s_axi_araddr,      // read address
    input  wire logic                         s_axi_arvalid,     // read address valid
    output logic                              s_axi_arready,     // read address ready
    output logic      [31:0]                  s_axi_rdata,       // read data
    output logic      [1:0]                   s_axi_rresp,       // read response
    output logic                              s_axi_rvalid,      // read data valid
    input  wire logic                         s_axi_rready       // read data ready
);

    logic [31:0]            mode_q;
    logic [31:0]            cfg_q       [NUM_CFG];
    logic [31:0]            status_q    [NUM_STATUS];
    logic [CNT_W-1:0]       cnt_value   [NUM_CNT];
    logic [CNT_W-1:0]       cycle_value;
    logic [NUM_CFG-1:0]     cfg_present;
    logic [NUM_STATUS-1:0]  status_present;
    logic [NUM_CNT-1:0]     cnt_present;
    logic [15:0]            rd_addr;
    logic [15:0]            wr_addr;
    logic [31:0]            rd_data;
    logic                   rd_ok;
    logic [NUM_STATUS-1:0]  rd_status_hit;
    logic                   wr_ok;
    logic                   wr_mode_hit;
    logic                   wr_tick_hit;
    logic [NUM_CFG-1:0]     wr_cfg_hit;
    logic                   rd_take;
    logic                   wr_take;
    logic                   tick_wr;
    logic                   snap_trig;

    // ****************************************************************
    // build variants
    // ****************************************************************
    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg_present
        assign cfg_present[i] = !((i <= FLOW_CFG_LAST) && !MAC_PCS)
                             && !((i == SPEED_CFG_IDX) && !RUNTIME_SWITCH);
    end

    for (genvar i = 0; i < NUM_STATUS; i++) begin : g_status_present
        assign status_present[i] = MAC_PCS || ((i != TX_PAUSE_IDX) && (i != RX_PAUSE_IDX));
    end

    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt_present
        assign cnt_present[i] = MAC_PCS || (i != TX_FRAME_IDX);
    end

    // ****************************************************************
    // address decode
    // ****************************************************************
    // word aligned; the two low address bits are ignored
    assign rd_addr = {s_axi_araddr[15:2], 2'b00};
    assign wr_addr = {s_axi_awaddr[15:2], 2'b00};

    always_comb begin
        rd_data       = '0;
        rd_ok         = 1'b0;
        rd_status_hit = '0;
        if (rd_addr == MODE_OFS) begin
            rd_data = mode_q;
            rd_ok   = 1'b1;
        end
        if (rd_addr == TICK_OFS) begin
            rd_ok = 1'b1;
        end
        for (int i = 0; i < NUM_CFG; i++) begin
            if (rd_addr == CFG_OFS[i] && cfg_present[i]) begin
                rd_data = cfg_q[i];
                rd_ok   = 1'b1;
            end
        end
        for (int i = 0; i < NUM_STATUS; i++) begin
            if (rd_addr == STATUS_OFS[i] && status_present[i]) begin
                rd_data          = status_q[i];
                rd_ok            = 1'b1;
                rd_status_hit[i] = 1'b1;
            end
        end
        if (rd_addr == CYCLE_OFS) begin
            rd_data = cycle_value[31:0];
            rd_ok   = 1'b1;
        end
        if (rd_addr == CYCLE_OFS + HI_WORD_STEP) begin
            rd_data = {16'h0000, cycle_value[CNT_W-1:32]};
            rd_ok   = 1'b1;
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            if (rd_addr == CNT_OFS[i] && cnt_present[i]) begin
                rd_data = cnt_value[i][31:0];
                rd_ok   = 1'b1;
            end
            if (rd_addr == CNT_OFS[i] + HI_WORD_STEP && cnt_present[i]) begin
                rd_data = {16'h0000, cnt_value[i][CNT_W-1:32]};
                rd_ok   = 1'b1;
            end
        end
    end

    // only control and configuration words take writes
    always_comb begin
        wr_mode_hit = (wr_addr == MODE_OFS);
        wr_tick_hit = (wr_addr == TICK_OFS);
        wr_cfg_hit  = '0;
        for (int i = 0; i < NUM_CFG; i++) begin
            wr_cfg_hit[i] = (wr_addr == CFG_OFS[i]) && cfg_present[i];
        end
        wr_ok = wr_mode_hit || wr_tick_hit || (|wr_cfg_hit);
    end

    // ****************************************************************
    // bus slave
    // ****************************************************************
    assign rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= wr_take;
            s_axi_wready  <= wr_take;
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // control and configuration registers
    // ****************************************************************
    // whole word is written whatever the byte strobes say
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_RESET;
        end else if (wr_take && wr_mode_hit) begin
            mode_q <= s_axi_wdata;
        end
    end

    for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                cfg_q[i] <= CFG_RESET;
            end else if (wr_take && wr_cfg_hit[i]) begin
                cfg_q[i] <= s_axi_wdata;
            end
        end
    end

    // ****************************************************************
    // snapshot trigger
    // ****************************************************************
    assign tick_wr   = wr_take && wr_tick_hit && s_axi_wdata[TICK_BIT];
    assign snap_trig = mode_q[TICK_SEL_BIT] ? tick_wr : snapshot_pulse_in;

    // ****************************************************************
    // clear-on-read status registers
    // ****************************************************************
    // a bit raised in the cycle of its read survives the clear
    for (genvar i = 0; i < NUM_STATUS; i++) begin : g_status
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                status_q[i] <= '0;
            end else if ((STATUS_SIDE[i] == SIDE_TX) && tx_reset) begin
                status_q[i] <= '0;
            end else if ((STATUS_SIDE[i] == SIDE_RX) && rx_reset) begin
                status_q[i] <= '0;
            end else if (rd_take && rd_status_hit[i]) begin
                status_q[i] <= status_set_in[i];
            end else begin
                status_q[i] <= status_q[i] | status_set_in[i];
            end
        end

        a_status_clear_read: assert property (@(posedge clock) disable iff (rst)
            rd_take && rd_status_hit[i] && !tx_reset && !rx_reset
            |=> status_q[i] == $past(status_set_in[i]))
            else $error("status word not cleared by its read");

        if (STATUS_SIDE[i] == SIDE_TX) begin : g_tx_chk
            a_tx_status_reset: assert property (@(posedge clock) disable iff (rst)
                tx_reset |=> status_q[i] == '0)
                else $error("transmit reset left a transmit status bit");
            a_tx_keep_rx_reset: assert property (@(posedge clock) disable iff (rst)
                rx_reset && !tx_reset && !(rd_take && rd_status_hit[i])
                |=> status_q[i] == ($past(status_q[i]) | $past(status_set_in[i])))
                else $error("receive reset disturbed a transmit status word");
        end
        if (STATUS_SIDE[i] == SIDE_RX) begin : g_rx_chk
            a_rx_status_reset: assert property (@(posedge clock) disable iff (rst)
                rx_reset |=> status_q[i] == '0)
                else $error("receive reset left a receive status bit");
        end
    end

    // ****************************************************************
    // statistics counters
    // ****************************************************************
    // every counter shares the one trigger, so all cover the same interval
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        stat_accum_counter u_cnt (
            .clock      (clock),
            .rst        (rst),
            .side_reset ((CNT_SIDE[i] == SIDE_TX) ? tx_reset : rx_reset),
            .event_in   (cnt_event_in[i]),
            .snapshot   (snap_trig),
            .value_q    (cnt_value[i])
        );
    end

    stat_accum_counter u_cycle (
        .clock      (clock),
        .rst        (rst),
        .side_reset (rx_reset),
        .event_in   (1'b1),
        .snapshot   (snap_trig),
        .value_q    (cycle_value)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    a_pin_mode_only: assert property (@(posedge clock) disable iff (rst)
        !mode_q[TICK_SEL_BIT] |-> (snap_trig == snapshot_pulse_in))
        else $error("pin mode trigger not taken from the pin");
    a_reg_mode_only: assert property (@(posedge clock) disable iff (rst)
        mode_q[TICK_SEL_BIT] && snapshot_pulse_in && !tick_wr |-> !snap_trig)
        else $error("register mode obeyed the pin");
    a_reserved_err: assert property (@(posedge clock) disable iff (rst)
        rd_take && !rd_ok |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
        else $error("reserved read not answered with an error");
    a_strobe_ignored: assert property (@(posedge clock) disable iff (rst)
        wr_take && wr_mode_hit |=> mode_q == $past(s_axi_wdata) && s_axi_bresp == RESP_OKAY)
        else $error("mode write not taken as a whole word");
    a_cycle_interval: assert property (@(posedge clock) disable iff (rst)
        snap_trig ##1 snap_trig && !$past(rx_reset) |=> cycle_value == {{(CNT_W-1){1'b0}}, 1'b1})
        else $error("interval count wrong for back to back triggers");
    a_ro_write_err: assert property (@(posedge clock) disable iff (rst)
        wr_take && !wr_ok |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("write to a read-only word accepted");

endmodule : eth_status_and_stats_regs

`default_nettype wire

// File: datapath_stub.sv
`timescale 1ns/1ps
`default_nettype none
module datapath_stub import eth_stats_pkg::*; (
    input  wire logic                        ev_go,   // pulse events
    input  wire logic [NUM_CNT-1:0]          ev_mask, // counters hit
    input  wire logic                        st_go,   // raise status
    input  wire logic [4:0]                  st_idx,  // status word
    input  wire logic [31:0]                 st_bits, // status bits
    output logic      [NUM_STATUS-1:0][31:0] st_out,  // status set
    output logic      [NUM_CNT-1:0]          ev_out   // event pulses
);
    // ****
    // datapath sources, one count per cycle high
    // ****
    assign ev_out = ev_go ? ev_mask : '0;
    always_comb begin
        st_out = '0;
        if (st_go) begin
            st_out[st_idx] = st_bits;
        end
    end
endmodule : datapath_stub
`default_nettype wire

// File: eth_status_and_stats_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eth_status_and_stats_regs_tb import eth_stats_pkg::*; ;
    logic clock, rst, tx_reset, rx_reset, snapshot_pulse_in, ev_go, st_go;
    logic [NUM_CNT-1:0] ev_mask, cnt_event_in;
    logic [4:0] st_idx;
    logic [31:0] st_bits, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [NUM_STATUS-1:0][31:0] status_set_in;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares, checks_done;
    eth_status_and_stats_regs u_eth_status_and_stats_regs (.clock, .rst, .tx_reset, .rx_reset,
        .snapshot_pulse_in, .status_set_in, .cnt_event_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    datapath_stub u_datapath_stub (.ev_go, .ev_mask, .st_go, .st_idx, .st_bits,
        .st_out(status_set_in), .ev_out(cnt_event_in));
    // ****
    // bus and source tasks
    // ****
    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int i = 0; i < 20 && s_axi_rvalid !== 1'b1; i++) @(negedge clock);
        check($sformatf("read %h", a), {r, d}, {s_axi_rresp, s_axi_rdata});
        @(posedge clock);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b0;
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int i = 0; i < 20 && s_axi_bvalid !== 1'b1; i++) @(negedge clock);
        check($sformatf("write %h", a), r, s_axi_bresp);
        @(posedge clock);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b0;
    endtask : wr
    task automatic raise(input logic [4:0] idx, input logic [31:0] bits);
        @(posedge clock);
        st_go   <= 1'b1;
        st_idx  <= idx;
        st_bits <= bits;
        @(posedge clock);
        st_go <= 1'b0;
    endtask : raise
    task automatic emit(input int n, input logic [NUM_CNT-1:0] m);
        @(posedge clock);
        ev_go   <= 1'b1;
        ev_mask <= m;
        repeat (n) @(posedge clock);
        ev_go <= 1'b0;
    endtask : emit
    task automatic pin();
        @(posedge clock);
        snapshot_pulse_in <= 1'b1;
        @(posedge clock);
        snapshot_pulse_in <= 1'b0;
    endtask : pin
    // ****
    // scenarios
    // ****
    task automatic test_clear_on_read();
        raise(0, 32'h0000_0011);
        rd(32'h0400, 32'h11, RESP_OKAY);
        rd(32'h0400, 32'h0, RESP_OKAY);
        wr(32'h0400, 32'hffff_ffff, RESP_SLVERR);
    endtask : test_clear_on_read
    task automatic test_path_resets();
        for (int j = 0; j < 2; j++) begin
            raise(0, 32'h0000_00a5);
            raise(1, 32'h0000_005a);
            @(posedge clock);
            tx_reset <= (j == 0);
            rx_reset <= (j == 1);
            @(posedge clock);
            tx_reset <= 1'b0;
            rx_reset <= 1'b0;
            rd(32'h0400, (j == 1) ? 32'ha5 : 32'h0, RESP_OKAY);
            rd(32'h0404, (j == 0) ? 32'h5a : 32'h0, RESP_OKAY);
        end
    endtask : test_path_resets
    task automatic test_pin_snapshot();
        logic [31:0] ofs [7] = '{32'h500, 32'h504, 32'h508, 32'h50c, 32'h510, 32'h6a0, 32'h508};
        logic [31:0] exp [7] = '{32'h8, 32'h0, 32'h5, 32'h0, 32'h0, 32'h5, 32'h5};
        pin();
        emit(5, 5'h11);
        pin();
        for (int i = 0; i < 7; i++) rd(ofs[i], exp[i], RESP_OKAY);
    endtask : test_pin_snapshot
    task automatic test_tick_mode();
        wr(32'h0008, 32'h4000_0000, RESP_OKAY);
        rd(32'h0008, 32'h4000_0000, RESP_OKAY);
        emit(3, 5'h02);
        pin();
        rd(32'h0510, 32'h0, RESP_OKAY);
        wr(32'h0020, 32'h1, RESP_OKAY);
        rd(32'h0510, 32'h3, RESP_OKAY);
        rd(32'h0508, 32'h0, RESP_OKAY);
    endtask : test_tick_mode
    task automatic test_resets();
        emit(2, 5'h11);
        @(posedge clock);
        tx_reset <= 1'b1;
        @(posedge clock);
        tx_reset <= 1'b0;
        wr(32'h0020, 32'h1, RESP_OKAY);
        rd(32'h0508, 32'h2, RESP_OKAY);
        rd(32'h06a0, 32'h0, RESP_OKAY);
        raise(2, 32'h0000_0003);
        emit(2, 5'h01);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        pin();
        rd(32'h0508, 32'h0, RESP_OKAY);
        rd(32'h0408, 32'h0, RESP_OKAY);
    endtask : test_resets
    task automatic test_reserved();
        rd(32'h0600, 32'h0, RESP_SLVERR);
        wr(32'h0600, 32'h1, RESP_SLVERR);
        rd(32'h013c, 32'h0, RESP_SLVERR);
    endtask : test_reserved
    task automatic complete_run();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
    initial begin
        {tx_reset, rx_reset, snapshot_pulse_in, ev_go, st_go, ev_mask, st_idx, st_bits} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, miscompares, checks_done} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        test_clear_on_read();
        test_path_resets();
        test_pin_snapshot();
        test_tick_mode();
        test_resets();
        test_reserved();
        complete_run();
    end
endmodule : eth_status_and_stats_regs_tb
`default_nettype wire
